// *** common/threshold_tables_pkg.sv ***
/*
 Shared constants and carriers for the temperature-indexed threshold tables.
 Assumes one clock domain and byte-wide accesses from a two-wire slave front end.
*/
package threshold_tables_pkg;

	// Serial slave addresses and page select
	localparam logic [7:0] SLAVE_AUX       = 8'hA0;
	localparam logic [7:0] SLAVE_TX_FIRST  = 8'hA2;
	localparam logic [7:0] SLAVE_TX_SECOND = 8'hB2;
	localparam logic [7:0] TABLE_PAGE      = 8'h06;

	// Table page offsets, and the upper-half base of the auxiliary memory
	localparam logic [7:0] GAP_FIRST          = 8'hC8;
	localparam logic [7:0] GAP_LAST           = 8'hDF;
	localparam logic [7:0] BIAS_TABLE_BASE    = 8'hE0;
	localparam logic [7:0] HIGH_TABLE_BASE    = 8'hE8;
	localparam logic [7:0] LOW_TABLE_BASE     = 8'hF0;
	localparam logic [7:0] OFFSET_TABLE_BASE  = 8'hF8;
	localparam logic [7:0] AUX_UPPER_BASE     = 8'h80;

	// Table select field inside the table offset
	localparam int         TABLE_SEL_LSB      = 3;
	localparam logic [1:0] SEL_BIAS           = 2'h0;
	localparam logic [1:0] SEL_HIGH           = 2'h1;
	localparam logic [1:0] SEL_LOW            = 2'h2;
	localparam logic [1:0] SEL_OFFSET         = 2'h3;

	localparam logic [7:0] BYTE_RESET         = 8'h00;
	localparam int         TX_COUNT           = 2;
	localparam int         TABLE_BYTES_PER_TX = 32;
	localparam int         AUX_BYTES          = 256;

	// Temperature bands, whole degrees
	localparam int               BAND_COUNT      = 8;
	localparam logic signed [9:0] BAND_FIRST_EDGE = -10'sd8;
	localparam logic signed [9:0] BAND_STEP       = 10'sd16;
	localparam logic signed [9:0] HYST_DEGREES    = 10'sd1;

	// Offset byte carries weights 2^9..2^2
	localparam int DAC_WIDTH    = 10;
	localparam int OFFSET_SHIFT = 2;

	typedef struct packed {
		logic       req;
		logic       write;
		logic [7:0] slave;
		logic [7:0] page;
		logic [7:0] offset;
		logic [7:0] wdata;
	} access_s;

	typedef struct packed {
		logic lowerPasswordLevel;
		logic upperPasswordLevel;
		logic tableAccessPermit;
		logic auxLowWritePermit;
		logic auxLowOpenWrite;
		logic auxHighWritePermit;
		logic auxHighOpenWrite;
	} permit_s;

	typedef struct packed {
		logic [7:0]           biasTripThreshold;
		logic [7:0]           powerHighTripThreshold;
		logic [7:0]           powerLowTripThreshold;
		logic [DAC_WIDTH-1:0] powerControlDac;
	} tx_out_s;

endpackage

// *** logic/temp_indexed_threshold_tables.sv ***
/*
 Per-transmitter temperature tables, band selection with hysteresis, power-control
 DAC code and the 256-byte auxiliary memory, with password gating.
 Assumes a two-wire slave front end on ref_clk presents one byte access per request,
 and the converter, password logic and manual DAC path share ref_clk.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - Bias trip threshold comes from eight-byte bias table, band-selected.
// - High power trip threshold comes from its own band-selected eight-byte table.
// - Low power trip threshold comes from a third band-selected eight-byte table.
// - Bands are sixteen degrees wide; first at or below -8, last above +88.
// - Falling temperature keeps the higher band until one degree below edge.
// - DAC code is table value plus four times the offset byte, ten bits.
// - Offset table holds eight bytes, one per band, weights 2^9 to 2^2.
// - Each transmitter has its own tables, chosen by A2h or B2h address.
// - Tables accessible under upper password, or lower plus table permit.
// - Offsets C8h to DFh of the table page do not exist.
// - Auxiliary memory at A0h, readable by anyone.
// - Lower aux half writes need upper, lower plus permit, or open write.
// - Upper aux half writes gated likewise by its own two bits.
// - DAC register loads table plus four times offset at each conversion end.
// - Manual enable stops automatic DAC updates; host writes DAC directly.
module temp_indexed_threshold_tables #(
	parameter int TX_COUNT = threshold_tables_pkg::TX_COUNT
) (
	input  wire logic                                           ref_clk,
	input  wire logic                                           reset_n,
	input  wire threshold_tables_pkg::access_s                  access,
	input  wire threshold_tables_pkg::permit_s                  permit,
	input  wire logic signed [7:0]                              tempDegrees,
	input  wire logic                                           convDone,
	input  wire logic [TX_COUNT-1:0][7:0]                       powerLutValue,
	input  wire logic [TX_COUNT-1:0]                            manualDacEnable,
	input  wire logic                                           manualDacWrite,
	input  wire logic                                           manualDacTx,
	input  wire logic [threshold_tables_pkg::DAC_WIDTH-1:0]     manualDacCode,
	output logic                                                accAck,
	output logic                                                accNak,
	output logic [7:0]                                          accRdata,
	output logic [2:0]                                          temperatureTableIndex,
	output threshold_tables_pkg::tx_out_s [TX_COUNT-1:0]        txOut
);

	////////////////////////////////////////////////////////////////////////////////

	// Count of band edges lying below temp once each edge is lowered by shift
	function automatic logic [2:0] bandCount(input logic signed [7:0] temp,
	                                         input logic signed [9:0] shift);
		logic signed [9:0] wideTemp;
		logic signed [9:0] edgeValue;
		logic [2:0]        n;
		wideTemp = temp;
		n = 3'h0;
		for (int k = 0; k < threshold_tables_pkg::BAND_COUNT - 1; k++) begin
			edgeValue = threshold_tables_pkg::BAND_FIRST_EDGE
			          + threshold_tables_pkg::BAND_STEP * 10'(k) - shift;
			if (wideTemp > edgeValue) begin
				n = n + 3'h1;
			end
		end
		return n;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Storage; nonvolatile in the part, modelled as zero-cleared flops

	logic [7:0] tableMem [0:TX_COUNT*threshold_tables_pkg::TABLE_BYTES_PER_TX-1];
	logic [7:0] auxMem   [0:threshold_tables_pkg::AUX_BYTES-1];

	////////////////////////////////////////////////////////////////////////////////
	// Access decode

	wire logic isTxFirst  = access.slave == threshold_tables_pkg::SLAVE_TX_FIRST;
	wire logic isTxSecond = access.slave == threshold_tables_pkg::SLAVE_TX_SECOND;
	wire logic isAux      = access.slave == threshold_tables_pkg::SLAVE_AUX;
	wire logic onPage     = (isTxFirst | isTxSecond)
	                      & (access.page == threshold_tables_pkg::TABLE_PAGE);
	wire logic inGap      = access.offset >= threshold_tables_pkg::GAP_FIRST
	                      && access.offset <= threshold_tables_pkg::GAP_LAST;
	wire logic inTables   = access.offset >= threshold_tables_pkg::BIAS_TABLE_BASE;

	wire logic tableOk = permit.upperPasswordLevel
	                   | (permit.lowerPasswordLevel & permit.tableAccessPermit);
	wire logic auxLowOk  = permit.upperPasswordLevel
	                     | (permit.lowerPasswordLevel & permit.auxLowWritePermit)
	                     | permit.auxLowOpenWrite;
	wire logic auxHighOk = permit.upperPasswordLevel
	                     | (permit.lowerPasswordLevel & permit.auxHighWritePermit)
	                     | permit.auxHighOpenWrite;
	wire logic auxUpper   = access.offset >= threshold_tables_pkg::AUX_UPPER_BASE;
	wire logic auxWriteOk = auxUpper ? auxHighOk : auxLowOk;

	// Gap offsets never match, so they are refused like any absent location
	wire logic tableHit  = onPage & inTables & ~inGap & tableOk;
	wire logic auxHit    = isAux & (~access.write | auxWriteOk);
	wire logic accepted  = access.req & (tableHit | auxHit);

	// Index = transmitter, table select, band
	wire logic [5:0] tableIndex = {isTxSecond, access.offset[4:0]};
	wire logic [7:0] readValue  = isAux ? auxMem[access.offset] : tableMem[tableIndex];

	wire logic writeTable = accepted & access.write & tableHit;
	wire logic writeAux   = accepted & access.write & isAux;

	////////////////////////////////////////////////////////////////////////////////
	// Register accesses

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			for (int i = 0; i < TX_COUNT*threshold_tables_pkg::TABLE_BYTES_PER_TX; i++) begin
				tableMem[i] <= threshold_tables_pkg::BYTE_RESET;
			end
		end else if (writeTable) begin
			tableMem[tableIndex] <= access.wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			for (int i = 0; i < threshold_tables_pkg::AUX_BYTES; i++) begin
				auxMem[i] <= threshold_tables_pkg::BYTE_RESET;
			end
		end else if (writeAux) begin
			auxMem[access.offset] <= access.wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			accAck   <= 1'b0;
			accNak   <= 1'b0;
			accRdata <= threshold_tables_pkg::BYTE_RESET;
		end else begin
			accAck   <= accepted;
			accNak   <= access.req & ~accepted;
			// Refused reads return zero rather than stale data
			accRdata <= (accepted & ~access.write) ? readValue
			                                      : threshold_tables_pkg::BYTE_RESET;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Band selection with falling hysteresis

	wire logic [2:0] risingBand  = bandCount(tempDegrees, 10'sd0);
	wire logic [2:0] holdingBand = bandCount(tempDegrees, threshold_tables_pkg::HYST_DEGREES);
	wire logic [2:0] fallenBand  = (holdingBand < temperatureTableIndex) ? holdingBand
	                                                                     : temperatureTableIndex;
	wire logic [2:0] next_band   = (risingBand >= temperatureTableIndex) ? risingBand
	                                                                     : fallenBand;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			temperatureTableIndex <= 3'h0;
		end else if (convDone) begin
			temperatureTableIndex <= next_band;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Per-transmitter outputs, loaded from the band chosen this conversion

	for (genvar t = 0; t < TX_COUNT; t++) begin : perTx
		wire logic [7:0] biasSel   = tableMem[{1'(t), threshold_tables_pkg::SEL_BIAS, next_band}];
		wire logic [7:0] highSel   = tableMem[{1'(t), threshold_tables_pkg::SEL_HIGH, next_band}];
		wire logic [7:0] lowSel    = tableMem[{1'(t), threshold_tables_pkg::SEL_LOW, next_band}];
		wire logic [7:0] offsetSel = tableMem[{1'(t), threshold_tables_pkg::SEL_OFFSET,
		                                       next_band}];
		// Sum wraps at ten bits; tables are expected to keep it in range
		wire logic [threshold_tables_pkg::DAC_WIDTH-1:0] autoCode =
			{2'h0, powerLutValue[t]}
			+ {offsetSel, {threshold_tables_pkg::OFFSET_SHIFT{1'b0}}};
		wire logic manualHit = manualDacWrite & (manualDacTx == 1'(t));

		threshold_tables_pkg::tx_out_s held;

		always_ff @(posedge ref_clk) begin
			if (!reset_n) begin
				held <= '0;
			end else begin
				if (convDone) begin
					held.biasTripThreshold      <= biasSel;
					held.powerHighTripThreshold <= highSel;
					held.powerLowTripThreshold  <= lowSel;
				end
				if (manualDacEnable[t]) begin
					if (manualHit) begin
						held.powerControlDac <= manualDacCode;
					end
				end else if (convDone) begin
					held.powerControlDac <= autoCode;
				end
			end
		end

		assign txOut[t] = held;
	end

endmodule

// *** sim/temp_indexed_threshold_tables_properties.sv ***
/* Port checker for the threshold tables: access answers, gating, band hold.
   Assumes it is bound to temp_indexed_threshold_tables on one clock. */
`timescale 1ns/1ps
module threshold_tables_checker #(
	parameter int TX_COUNT = 2
) (
	input wire logic                                        ref_clk,
	input wire logic                                        reset_n,
	input wire threshold_tables_pkg::access_s               access,
	input wire threshold_tables_pkg::permit_s               permit,
	input wire logic signed [7:0]                           tempDegrees,
	input wire logic                                        convDone,
	input wire logic [TX_COUNT-1:0]                         manualDacEnable,
	input wire logic                                        manualDacWrite,
	input wire logic                                        manualDacTx,
	input wire logic [9:0]                                  manualDacCode,
	input wire logic                                        accAck,
	input wire logic                                        accNak,
	input wire logic [7:0]                                  accRdata,
	input wire logic [2:0]                                  temperatureTableIndex,
	input wire threshold_tables_pkg::tx_out_s [TX_COUNT-1:0] txOut
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	wire logic aux = access.req && access.slave == threshold_tables_pkg::SLAVE_AUX;
	wire logic tbl = access.req && !aux;
	wire logic rd = access.req && !access.write;
	wire logic gap = access.offset >= 8'hC8 && access.offset <= 8'hDF;
	wire logic up = permit.upperPasswordLevel;
	wire logic lo = permit.lowerPasswordLevel;
	wire logic loOk = up || lo && permit.auxLowWritePermit || permit.auxLowOpenWrite;
	wire logic hiOk = up || lo && permit.auxHighWritePermit || permit.auxHighOpenWrite;

	AST_ONE_ANSWER: assert property (access.req |=> accAck != accNak)
		else $error("access answer missing or doubled");
	AST_NO_EXTRA: assert property (!access.req |=> !accAck && !accNak)
		else $error("answer without request");
	AST_RDATA_IDLE: assert property (!rd || accNak |=> accRdata == 8'h00)
		else $error("read data not cleared");
	AST_GAP: assert property (tbl && gap |=> accNak)
		else $error("gap offset answered");
	AST_TABLE_LOCK: assert property (tbl && !up && !(lo && permit.tableAccessPermit) |=> accNak)
		else $error("locked table access accepted");
	AST_AUX_READ: assert property (aux && rd |=> accAck)
		else $error("aux read refused");
	AST_AUX_LOW: assert property (aux && access.write && !access.offset[7] && !loOk |=> accNak)
		else $error("lower aux write accepted");
	AST_AUX_HIGH: assert property (aux && access.write && access.offset[7] && !hiOk |=> accNak)
		else $error("upper aux write accepted");
	AST_HOLD: assert property (!convDone && !manualDacWrite |=> $stable(txOut) && $stable(temperatureTableIndex))
		else $error("outputs moved between conversions");
	AST_TOP_BAND: assert property (convDone && tempDegrees > 8'sd88 |=> temperatureTableIndex == 3'h7)
		else $error("top band not chosen");
	AST_LOW_BAND: assert property (convDone && tempDegrees < -8'sd8 |=> temperatureTableIndex == 3'h0)
		else $error("bottom band not chosen");
	AST_MANUAL: assert property (manualDacWrite && manualDacEnable[manualDacTx]
		|=> txOut[$past(manualDacTx)].powerControlDac == $past(manualDacCode))
		else $error("manual dac code not loaded");
endmodule

bind temp_indexed_threshold_tables threshold_tables_checker #(.TX_COUNT(TX_COUNT)) chk_inst (
	.ref_clk(ref_clk), .reset_n(reset_n), .access(access), .permit(permit),
	.tempDegrees(tempDegrees), .convDone(convDone), .manualDacEnable(manualDacEnable),
	.manualDacWrite(manualDacWrite), .manualDacTx(manualDacTx), .manualDacCode(manualDacCode),
	.accAck(accAck), .accNak(accNak), .accRdata(accRdata),
	.temperatureTableIndex(temperatureTableIndex), .txOut(txOut));

// *** sim/host_master_model.sv ***
/* Host side model: issues one byte access per call on the access port.
   Assumes the bus engine presents a one-cycle request pulse, page 06h. */
`timescale 1ns/1ps
module host_master_model (
	input  wire logic                    ref_clk,
	output threshold_tables_pkg::access_s access
);
	initial access = '0;
	task automatic xfer(input logic wr, input logic [7:0] slv, off, dat);
		@(negedge ref_clk);
		access <= '{1'b1, wr, slv, 8'h06, off, dat};
		@(negedge ref_clk);
		// Released lines show junk, never the last value
		access <= '{1'b0, ~wr, ~slv, 8'hF9, ~off, ~dat};
	endtask
endmodule

// *** sim/tb_temp_indexed_threshold_tables.sv ***
/* Self-checking bench for the threshold tables and auxiliary memory.
   Assumes host_master_model drives access and the checker is bound. */
`timescale 1ns/1ps
module tb_temp_indexed_threshold_tables;
	logic ref_clk, reset_n, convDone, manualDacWrite, manualDacTx;
	logic signed [7:0] tempDegrees;
	logic [1:0][7:0] powerLutValue;
	logic [1:0] manualDacEnable;
	logic [9:0] manualDacCode, mcode;
	threshold_tables_pkg::access_s access;
	threshold_tables_pkg::permit_s permit;
	logic accAck, accNak;
	logic [7:0] accRdata, d;
	logic [2:0] temperatureTableIndex, band;
	threshold_tables_pkg::tx_out_s [1:0] txOut;
	int err_total = 0, checked = 0;
	logic [8:0] notes[$];
	logic [7:0] tbl[2][32];
	logic ok;
	localparam logic [7:0] AUX = threshold_tables_pkg::SLAVE_AUX;
	localparam logic [7:0] TX0 = threshold_tables_pkg::SLAVE_TX_FIRST;
	localparam logic [7:0] TX1 = threshold_tables_pkg::SLAVE_TX_SECOND;

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	temp_indexed_threshold_tables temp_indexed_threshold_tables_inst (.ref_clk(ref_clk),
		.reset_n(reset_n), .access(access), .permit(permit), .tempDegrees(tempDegrees),
		.convDone(convDone), .powerLutValue(powerLutValue), .manualDacEnable(manualDacEnable),
		.manualDacWrite(manualDacWrite), .manualDacTx(manualDacTx), .manualDacCode(manualDacCode),
		.accAck(accAck), .accNak(accNak), .accRdata(accRdata),
		.temperatureTableIndex(temperatureTableIndex), .txOut(txOut));
	host_master_model host_master_model_inst (.ref_clk(ref_clk), .access(access));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic acc(logic wr, logic [7:0] slv, off, dat, logic nak, logic [7:0] rd);
		notes.push_back({nak, rd});
		host_master_model_inst.xfer(wr, slv, off, dat);
	endtask
	// Hysteresis: falling keeps the higher band until a degree below the edge
	function automatic logic [2:0] nb(int t, logic [2:0] c);
		int up = 0;
		int dn = 0;
		for (int e = -8; e <= 88; e += 16) begin
			up += int'(t > e);
			dn += int'(t >= e);
		end
		return (up < c) ? ((dn < c) ? 3'(dn) : c) : 3'(up);
	endfunction
	task automatic conv(int t);
		logic [1:0][7:0] lut;
		logic [9:0] dac;
		lut = 16'($urandom);
		@(negedge ref_clk);
		tempDegrees <= t[7:0];
		powerLutValue <= lut;
		convDone <= 1'b1;
		band = nb(t, band);
		@(negedge ref_clk);
		convDone <= 1'b0;
		@(negedge ref_clk);
		chk("band", band, temperatureTableIndex);
		for (int x = 0; x < 2; x++) begin
			dac = manualDacEnable[x] ? mcode : 10'(lut[x]) + {tbl[x][24+band], 2'b00};
			chk("bias", tbl[x][band], txOut[x].biasTripThreshold);
			chk("high", tbl[x][8+band], txOut[x].powerHighTripThreshold);
			chk("low", tbl[x][16+band], txOut[x].powerLowTripThreshold);
			chk("dac", dac, txOut[x].powerControlDac);
		end
	endtask
	task automatic test_done;
		$display("TB: %0d checks, %0d mismatches", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always @(negedge ref_clk) begin
		if (accAck === 1'b1 || accNak === 1'b1) begin
			if (notes.size() == 0)
				chk("unexpected answer", 16'h0000, 16'h0001);
			else
				chk("answer", 16'(notes.pop_front()), {7'h00, accNak, accRdata});
		end
	end
	initial begin
		#200000;
		err_total++;
		test_done();
	end
	initial begin
		{reset_n, convDone, manualDacWrite, manualDacTx, tempDegrees} = '0;
		{powerLutValue, manualDacEnable, manualDacCode, mcode, band} = '0;
		permit = '0;
		void'($urandom(26));
		repeat (20) @(negedge ref_clk);
		reset_n = 1'b1;
		acc(1'b0, AUX, 8'h10, 8'h00, 1'b0, 8'h00);
		acc(1'b0, TX0, 8'hE0, 8'h00, 1'b1, 8'h00);
		permit.upperPasswordLevel = 1'b1;
		acc(1'b0, TX1, 8'hF8, 8'h00, 1'b0, 8'h00);
		acc(1'b0, TX0, 8'hC8, 8'h00, 1'b1, 8'h00);
		acc(1'b1, TX1, 8'hDF, 8'h55, 1'b1, 8'h00);
		for (int i = 0; i < 64; i++) begin
			tbl[i/32][i%32] = 8'($urandom);
			acc(1'b1, i < 32 ? TX0 : TX1, 8'hE0 + 8'(i % 32), tbl[i/32][i%32], 1'b0, 8'h00);
		end
		permit = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
		acc(1'b0, TX0, 8'hFF, 8'h00, 1'b0, tbl[0][31]);
		acc(1'b0, TX1, 8'hE0, 8'h00, 1'b0, tbl[1][0]);
		permit.tableAccessPermit = 1'b0;
		acc(1'b1, TX0, 8'hE5, 8'h00, 1'b1, 8'h00);
		$display("TB: table access test done");
		for (int k = 0; k < 32; k++) begin
			permit = '{k[1], k[0], 1'b0, k[2], k[3], k[3], k[2]};
			ok = k[4] ? (k[0] | k[1] & k[3] | k[2]) : (k[0] | k[1] & k[2] | k[3]);
			d = 8'($urandom);
			acc(1'b1, AUX, {k[4], 7'(k)}, d, !ok, 8'h00);
			acc(1'b0, AUX, {k[4], 7'(k)}, 8'h00, 1'b0, ok ? d : 8'h00);
		end
		$display("TB: aux gating test done");
		permit = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
		foreach (tbl[0][i]) begin
			conv(i == 0 ? -8 : i == 1 ? -7 : i == 2 ? 30 : i == 3 ? 89 : i == 4 ? 88
				: i == 5 ? 87 : i == 6 ? 8 : i == 7 ? 7 : -9);
			if (i > 8)
				break;
		end
		tbl[0][3] = 8'($urandom);
		acc(1'b1, TX0, 8'hE3, tbl[0][3], 1'b0, 8'h00);
		conv(30);
		$display("TB: conversion test done");
		mcode = 10'($urandom);
		manualDacEnable = 2'b10;
		manualDacTx = 1'b1;
		manualDacCode = mcode;
		manualDacWrite = 1'b1;
		@(negedge ref_clk);
		manualDacWrite = 1'b0;
		conv(50);
		$display("TB: manual dac test done");
		chk("notes left", 16'h0000, 16'(notes.size()));
		test_done();
	end
endmodule
